// [inc/bus_ctl_regs.vh]
`ifndef BUS_CTL_REGS_VH
`define BUS_CTL_REGS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_BUS_CONTROL 8'h00
`define ADDR_BUS_STATUS_PRIMARY 8'h04
`define ADDR_BUS_STATUS_SECONDARY 8'h08
`define ADDR_DATA_REGISTER 8'h0c

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CR_UNIT_ON 5
`define CR_GC_EN 4
`define CR_START 3
`define CR_ACK 2
`define CR_STOP 1
`define CR_IRQ_EN 0

// ----------------------------------------
// Primary status fields
// ----------------------------------------
`define SR1_EVENT 7
`define SR1_HDR10 6
`define SR1_SENT 5
`define SR1_BUSY 4
`define SR1_BYTE_DONE 3
`define SR1_ADDR_HIT 2
`define SR1_MASTER 1
`define SR1_START_SENT 0

// ----------------------------------------
// Secondary status fields
// ----------------------------------------
`define SR2_ACK_FAIL 4
`define SR2_STOP_SEEN 3
`define SR2_ARB_LOST 2
`define SR2_BUS_ERROR 1
`define SR2_GC_SEEN 0

`endif

// [src/bus_ctl_events.v]
`timescale 1ns/1ps
`include "bus_ctl_regs.vh"

// Operation
// - All events share one interrupt, gated by enable bit and CPU mask.
// - Every event may wake the core from Wait, none from Halt.
// - Unit off clears all control and status except stop request, releases bus.
// - First enabling write sets only the enable bit; second write takes fields.
// - Unit on switches the pins to their bus alternate function.
// - General call acknowledges 00h, ignores 01h, receive only; clears when off.
// - Start request gives Start; cleared when sent or unit off.
// - Acknowledge enable drives ack after received bytes; clears when off.
// - Master stop request gives Stop; hardware clears it; off keeps it.
// - Slave stop request releases both lines after current byte; software clears.
// - Interrupt enable gates all interrupts and clears when unit off.
// - Clock held low while header, start, byte done, address hit or post-address.
// - Event flag follows any event flag, address sent, and their clearing.
// - Header flag sets after 10-bit header; cleared by SR2 read then data write.
// - Direction flag shows sent or received byte; clears with byte done, stop, loss.
// - Busy sets on Start, clears on Stop or bus error.
// - Sent byte done after ack pulse; cleared by SR1 read then data write.
// - Received byte done after ack sent; cleared by SR1 read then data read.
// - Address hit on own or general call address; cleared by SR1 read or off.
// - Master flag sets on start request; clears on Stop, arbitration loss, off.
// - Start sent flag sets on Start; cleared by SR1 read then address write.
// - Error flags clear on secondary status read or unit off.
module bus_ctl_events
(
  // Clock, reset, enable
  input wire I_CLOCK,
  input wire I_RST_N,
  input wire I_CLK_EN,
  // APB slave
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [7:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output reg [31:0] O_PRDATA,
  output reg O_PREADY,
  output reg O_PSLVERR,
  // Bus pins, sampled only
  input wire I_SCL,
  input wire I_SDA,
  // Core power state and mask
  input wire I_CPU_IMASK,
  input wire I_HALT_MODE,
  // Events from the shift engine
  input wire I_EV_START_SENT,
  input wire I_EV_STOP_SENT,
  input wire I_EV_HEADER_SENT,
  input wire I_EV_ADDR_SENT,
  input wire I_EV_BYTE_TX,
  input wire I_EV_BYTE_RX,
  input wire I_EV_ADDR_MATCH,
  input wire I_EV_GEN_CALL,
  input wire I_EV_ACK_FAIL,
  input wire I_EV_ARB_LOST,
  input wire I_EV_BUS_ERROR,
  input wire [7:0] I_DR_RDATA,
  // Controls to the shift engine
  output reg O_SCL_HOLD,
  output reg O_RELEASE,
  output reg O_PIN_ALT,
  output reg O_START_REQ,
  output reg O_STOP_REQ,
  output reg O_ACK_EN,
  output reg O_GC_EN,
  output reg O_DR_WR,
  output reg O_DR_RD,
  output reg [7:0] O_DR_WDATA,
  // Core interrupt and wake
  output reg O_IRQ,
  output reg O_WAKE
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg unit_on_bit;
  reg general_call_enable;
  reg start_req;
  reg ack_en;
  reg stop_req;
  reg irq_enable;
  reg ten_bit_header_sent;
  reg sent_not_received;
  reg bus_busy;
  reg byte_done;
  reg own_address_hit;
  reg master_role;
  reg start_sent;
  reg post_address_event;
  reg ack_failure;
  reg stop_seen;
  reg arbitration_lost;
  reg bus_error;
  reg general_call_seen;
  reg addressed;
  reg sr1_read_seen;
  reg sr2_read_seen;
  reg scl_s1;
  reg scl_s2;
  reg sda_s1;
  reg sda_s2;
  reg sda_prev;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire acc = I_PSEL & I_PENABLE & O_PREADY & I_CLK_EN;
  wire wr = acc & I_PWRITE;
  wire rd = acc & ~I_PWRITE;
  wire sel_cr = (I_PADDR == `ADDR_BUS_CONTROL);
  wire sel_sr1 = (I_PADDR == `ADDR_BUS_STATUS_PRIMARY);
  wire sel_sr2 = (I_PADDR == `ADDR_BUS_STATUS_SECONDARY);
  wire sel_dr = (I_PADDR == `ADDR_DATA_REGISTER);
  wire mapped = sel_cr | sel_sr1 | sel_sr2 | sel_dr;
  wire cr_wr = wr & sel_cr;
  wire dr_wr = wr & sel_dr;
  wire dr_rd = rd & sel_dr;
  wire sr1_rd = rd & sel_sr1;
  wire sr2_rd = rd & sel_sr2;
  // Enabling write from off arms only the enable bit
  wire cr_full = cr_wr & unit_on_bit & I_PWDATA[`CR_UNIT_ON];
  wire cr_off = cr_wr & ~I_PWDATA[`CR_UNIT_ON];

  // ----------------------------------------
  // Line condition detect
  // ----------------------------------------
  // Start and Stop seen on the synchronised lines, SDA moving under high SCL
  wire line_start = scl_s2 & sda_prev & ~sda_s2;
  wire line_stop = scl_s2 & ~sda_prev & sda_s2;

  // ----------------------------------------
  // Clearing sequences
  // ----------------------------------------
  wire clr_sb = sr1_read_seen & dr_wr;
  wire clr_hdr = sr2_read_seen & dr_wr;
  wire clr_btf = sr1_read_seen & ((dr_wr & sent_not_received) |
                 (dr_rd & ~sent_not_received));
  wire clr_post = sr1_read_seen & cr_wr;

  wire [7:0] sr1_val;
  wire [7:0] sr2_val;
  wire [7:0] cr_val;
  wire evt_any = ten_bit_header_sent | byte_done | own_address_hit | start_sent |
                 post_address_event | ack_failure | stop_seen | arbitration_lost |
                 bus_error;

  assign cr_val = {2'b00, unit_on_bit, general_call_enable, start_req, ack_en,
                   stop_req, irq_enable};
  assign sr1_val = {evt_any, ten_bit_header_sent, sent_not_received, bus_busy,
                    byte_done, own_address_hit, master_role, start_sent};
  assign sr2_val = {3'b000, ack_failure, stop_seen, arbitration_lost, bus_error,
                    general_call_seen};

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_prev <= 1'b1;
    end
    else if (I_CLK_EN)
    begin
      scl_s1 <= I_SCL;
      scl_s2 <= scl_s1;
      sda_s1 <= I_SDA;
      sda_s2 <= sda_s1;
      sda_prev <= sda_s2;
    end
  end

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  always @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_PREADY <= 1'b0;
      O_PRDATA <= `RST_WORD;
      O_PSLVERR <= 1'b0;
    end
    else if (I_CLK_EN)
    begin
      O_PREADY <= I_PSEL & I_PENABLE & ~O_PREADY;
      O_PSLVERR <= I_PSEL & I_PENABLE & ~O_PREADY & ~mapped;
      if (I_PSEL & I_PENABLE & ~O_PREADY & ~I_PWRITE)
      begin
        if (sel_cr)
          O_PRDATA <= {24'h000000, cr_val};
        else if (sel_sr1)
          O_PRDATA <= {24'h000000, sr1_val};
        else if (sel_sr2)
          O_PRDATA <= {24'h000000, sr2_val};
        else if (sel_dr)
          O_PRDATA <= {24'h000000, I_DR_RDATA};
        else
          O_PRDATA <= `RST_WORD;
      end
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // All flags are plain CPU-clock flops; bus timing sits in the divider block
  always @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      unit_on_bit <= 1'b0;
      general_call_enable <= 1'b0;
      start_req <= 1'b0;
      ack_en <= 1'b0;
      stop_req <= 1'b0;
      irq_enable <= 1'b0;
    end
    else if (I_CLK_EN)
    begin
      if (cr_wr)
        unit_on_bit <= I_PWDATA[`CR_UNIT_ON];
      if (cr_off || !unit_on_bit)
      begin
        general_call_enable <= 1'b0;
        start_req <= 1'b0;
        ack_en <= 1'b0;
        irq_enable <= 1'b0;
        // Only a disabling write may touch the stop bit while off
        if (cr_off)
          stop_req <= I_PWDATA[`CR_STOP];
      end
      else if (cr_full)
      begin
        general_call_enable <= I_PWDATA[`CR_GC_EN];
        start_req <= I_PWDATA[`CR_START] & ~I_EV_START_SENT;
        ack_en <= I_PWDATA[`CR_ACK];
        irq_enable <= I_PWDATA[`CR_IRQ_EN];
        stop_req <= I_PWDATA[`CR_STOP] & ~(I_EV_STOP_SENT & master_role);
      end
      else
      begin
        if (I_EV_START_SENT)
          start_req <= 1'b0;
        // Slave-role stop request stays until software drops it
        if (I_EV_STOP_SENT && master_role)
          stop_req <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  always @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      ten_bit_header_sent <= 1'b0;
      sent_not_received <= 1'b0;
      bus_busy <= 1'b0;
      byte_done <= 1'b0;
      own_address_hit <= 1'b0;
      master_role <= 1'b0;
      start_sent <= 1'b0;
      post_address_event <= 1'b0;
      ack_failure <= 1'b0;
      stop_seen <= 1'b0;
      arbitration_lost <= 1'b0;
      bus_error <= 1'b0;
      general_call_seen <= 1'b0;
      addressed <= 1'b0;
      sr1_read_seen <= 1'b0;
      sr2_read_seen <= 1'b0;
    end
    else if (I_CLK_EN)
    begin
      if (!unit_on_bit || cr_off)
      begin
        // Whole status cleared while off; busy too, as it is part of it
        ten_bit_header_sent <= 1'b0;
        sent_not_received <= 1'b0;
        bus_busy <= 1'b0;
        byte_done <= 1'b0;
        own_address_hit <= 1'b0;
        master_role <= 1'b0;
        start_sent <= 1'b0;
        post_address_event <= 1'b0;
        ack_failure <= 1'b0;
        stop_seen <= 1'b0;
        arbitration_lost <= 1'b0;
        bus_error <= 1'b0;
        general_call_seen <= 1'b0;
        addressed <= 1'b0;
        sr1_read_seen <= 1'b0;
        sr2_read_seen <= 1'b0;
      end
      else
      begin
        // Sequence trackers: armed by a status read, spent on the next data register access; the SR1 one also on a control write
        if (sr1_rd)
          sr1_read_seen <= 1'b1;
        else if (dr_wr || dr_rd || cr_wr)
          sr1_read_seen <= 1'b0;
        if (sr2_rd)
          sr2_read_seen <= 1'b1;
        else if (dr_wr || dr_rd)
          sr2_read_seen <= 1'b0;

        // In each flag except busy and master the set term stands last so it wins over a clear; in those two the clear wins
        if (line_stop || I_EV_BUS_ERROR)
          bus_busy <= 1'b0;
        else if (line_start)
          bus_busy <= 1'b1;

        if (clr_hdr)
          ten_bit_header_sent <= 1'b0;
        if (I_EV_HEADER_SENT)
          ten_bit_header_sent <= 1'b1;

        if (clr_sb)
          start_sent <= 1'b0;
        if (I_EV_START_SENT)
          start_sent <= 1'b1;

        if (clr_post)
          post_address_event <= 1'b0;
        if (I_EV_ADDR_SENT)
          post_address_event <= 1'b1;

        if (clr_btf)
          byte_done <= 1'b0;
        if (I_EV_BYTE_TX || I_EV_BYTE_RX)
          byte_done <= 1'b1;

        if (clr_btf || line_stop || I_EV_ARB_LOST)
          sent_not_received <= 1'b0;
        if (I_EV_BYTE_TX || I_EV_BYTE_RX)
          sent_not_received <= I_EV_BYTE_TX;

        if (sr1_rd)
          own_address_hit <= 1'b0;
        // Address 01h never reaches a match; general call only while enabled
        if (I_EV_ADDR_MATCH && (!I_EV_GEN_CALL || general_call_enable))
          own_address_hit <= 1'b1;

        if (line_stop)
          general_call_seen <= 1'b0;
        if (I_EV_ADDR_MATCH && I_EV_GEN_CALL && general_call_enable)
          general_call_seen <= 1'b1;

        if (line_stop)
          addressed <= 1'b0;
        if (I_EV_ADDR_MATCH)
          addressed <= 1'b1;

        if (line_stop || I_EV_ARB_LOST)
          master_role <= 1'b0;
        else if ((start_req && !bus_busy) || I_EV_START_SENT)
          master_role <= 1'b1;

        if (sr2_rd)
        begin
          ack_failure <= 1'b0;
          stop_seen <= 1'b0;
          arbitration_lost <= 1'b0;
          bus_error <= 1'b0;
        end
        if (I_EV_ACK_FAIL)
          ack_failure <= 1'b1;
        if (line_stop && addressed && !master_role)
          stop_seen <= 1'b1;
        if (I_EV_ARB_LOST)
          arbitration_lost <= 1'b1;
        if (I_EV_BUS_ERROR)
          bus_error <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Engine controls and data port
  // ----------------------------------------
  always @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_SCL_HOLD <= 1'b0;
      O_RELEASE <= 1'b1;
      O_PIN_ALT <= 1'b0;
      O_START_REQ <= 1'b0;
      O_STOP_REQ <= 1'b0;
      O_ACK_EN <= 1'b0;
      O_GC_EN <= 1'b0;
      O_DR_WR <= 1'b0;
      O_DR_RD <= 1'b0;
      O_DR_WDATA <= `RST_BYTE;
      O_IRQ <= 1'b0;
      O_WAKE <= 1'b0;
    end
    else if (I_CLK_EN)
    begin
      // Error flags do not stretch the clock; only these do
      O_SCL_HOLD <= unit_on_bit & (ten_bit_header_sent | start_sent | byte_done |
                    own_address_hit | post_address_event);
      // One cycle lag after a flag sets; engine stalls at bit edges anyway
      O_RELEASE <= ~unit_on_bit | (stop_req & ~master_role & byte_done);
      O_PIN_ALT <= unit_on_bit;
      O_START_REQ <= start_req;
      O_STOP_REQ <= stop_req & master_role;
      O_ACK_EN <= ack_en;
      O_GC_EN <= general_call_enable;
      O_DR_WR <= dr_wr;
      O_DR_RD <= dr_rd;
      if (dr_wr)
        O_DR_WDATA <= I_PWDATA[7:0];
      O_IRQ <= evt_any & irq_enable & ~I_CPU_IMASK;
      // Halt stops the wake path entirely
      O_WAKE <= evt_any & irq_enable & ~I_HALT_MODE;
    end
  end

endmodule

// [bench/bus_ctl_checker.sv]
`timescale 1ns/1ps
`include "bus_ctl_regs.vh"
// ----------------------------------------
// Port-level checks
// ----------------------------------------
module bus_ctl_checker
(
  input wire I_CLOCK,
  input wire I_RST_N,
  input wire I_CLK_EN,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [7:0] I_PADDR,
  input wire O_PREADY,
  input wire O_PSLVERR,
  input wire I_CPU_IMASK,
  input wire I_HALT_MODE,
  input wire I_EV_START_SENT,
  input wire O_SCL_HOLD,
  input wire O_RELEASE,
  input wire O_PIN_ALT,
  input wire O_START_REQ,
  input wire O_ACK_EN,
  input wire O_GC_EN,
  input wire O_DR_WR,
  input wire O_DR_RD,
  input wire O_IRQ,
  input wire O_WAKE
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  wire dr_take = I_PSEL && I_PENABLE && O_PREADY && I_PADDR == `ADDR_DATA_REGISTER;
  a_irq_mask: assert property (O_IRQ |-> !$past(I_CPU_IMASK))
    else $error("irq while masked");
  a_wake_halt: assert property (O_WAKE |-> !$past(I_HALT_MODE))
    else $error("wake while halted");
  // Two cycles off, so the registered irq and hold have settled
  a_off_quiet: assert property ((!O_PIN_ALT && !$past(O_PIN_ALT)) |-> (O_RELEASE &&
    !O_SCL_HOLD && !O_IRQ && !O_START_REQ && !O_ACK_EN && !O_GC_EN))
    else $error("unit off but outputs active");
  a_ready_once: assert property (O_PREADY |=> !O_PREADY)
    else $error("pready longer than one cycle");
  a_ready_wait: assert property ((I_PSEL && I_PENABLE && !$past(I_PENABLE))
    |-> !O_PREADY ##1 O_PREADY)
    else $error("pready not after one wait state");
  a_err_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("pslverr without pready");
  a_err_map: assert property ((O_PREADY && (I_PADDR > 8'h0c || I_PADDR[1:0] != 2'h0))
    |-> O_PSLVERR)
    else $error("unmapped access not refused");
  a_start_hold: assert property ((I_EV_START_SENT && O_PIN_ALT && I_CLK_EN) |-> ##2 O_SCL_HOLD)
    else $error("no clock hold after start");
  a_dr_write: assert property ((dr_take && I_PWRITE) |-> ##[1:2] O_DR_WR)
    else $error("data write not passed on");
  a_dr_read: assert property ((dr_take && !I_PWRITE) |-> ##[1:2] O_DR_RD)
    else $error("data read not passed on");
endmodule

bind bus_ctl_events bus_ctl_checker i_bus_ctl_checker (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
  .I_CLK_EN(I_CLK_EN),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_CPU_IMASK(I_CPU_IMASK),
  .I_HALT_MODE(I_HALT_MODE), .I_EV_START_SENT(I_EV_START_SENT), .O_SCL_HOLD(O_SCL_HOLD),
  .O_RELEASE(O_RELEASE), .O_PIN_ALT(O_PIN_ALT), .O_START_REQ(O_START_REQ),
  .O_ACK_EN(O_ACK_EN), .O_GC_EN(O_GC_EN), .O_DR_WR(O_DR_WR), .O_DR_RD(O_DR_RD),
  .O_IRQ(O_IRQ), .O_WAKE(O_WAKE));

// [bench/bus_line_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Far-side bus traffic
// ----------------------------------------
module bus_line_model
(
  input wire clk,
  input wire frame,
  output logic scl,
  output logic sda
);
  // Lines idle high on the pull-ups; clock runs only inside a frame
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
    forever
    begin
      wait (frame);
      @(posedge clk);
      sda <= 1'b0;
      repeat (4) @(posedge clk);
      while (frame)
      begin
        scl <= ~scl;
        repeat (4) @(posedge clk);
      end
      scl <= 1'b1;
      repeat (4) @(posedge clk);
      sda <= 1'b1;
    end
  end
endmodule

// [bench/tb_bus_ctl_events.sv]
`timescale 1ns/1ps
`include "bus_ctl_regs.vh"
// ----------------------------------------
// Testbench
// ----------------------------------------
module tb_bus_ctl_events;
  logic clk, rst_n, psel, penable, pwrite, imask, halt, frame, err, ck;
  logic [7:0] paddr, rdata8;
  logic [31:0] pwdata, rd;
  logic [10:0] ev;
  wire [31:0] prdata;
  wire [7:0] drw;
  wire pready, pslverr, scl, sda, hold, rel, alt, sreq, preq, acken, gcen, drwr, drrd, irq, wake;
  int n_errors, compares;

  bus_ctl_events i_bus_ctl_events (.I_CLOCK(clk), .I_RST_N(rst_n), .I_CLK_EN(ck),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_SCL(scl), .I_SDA(sda), .I_CPU_IMASK(imask), .I_HALT_MODE(halt),
    .I_EV_START_SENT(ev[0]), .I_EV_STOP_SENT(ev[1]), .I_EV_HEADER_SENT(ev[2]),
    .I_EV_ADDR_SENT(ev[3]), .I_EV_BYTE_TX(ev[4]), .I_EV_BYTE_RX(ev[5]),
    .I_EV_ADDR_MATCH(ev[6]), .I_EV_GEN_CALL(ev[7]), .I_EV_ACK_FAIL(ev[8]),
    .I_EV_ARB_LOST(ev[9]), .I_EV_BUS_ERROR(ev[10]), .I_DR_RDATA(rdata8),
    .O_SCL_HOLD(hold), .O_RELEASE(rel), .O_PIN_ALT(alt), .O_START_REQ(sreq),
    .O_STOP_REQ(preq), .O_ACK_EN(acken), .O_GC_EN(gcen), .O_DR_WR(drwr), .O_DR_RD(drrd),
    .O_DR_WDATA(drw), .O_IRQ(irq), .O_WAKE(wake));
  bus_line_model i_bus_line_model (.clk(clk), .frame(frame), .scl(scl), .sda(sda));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task complete_run;
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask

  // Request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++)
      @(posedge clk);
    if (pready !== 1'b1)
    begin
      n_errors++;
      $display("[ERR] pready exp 1 got %b", pready);
      complete_run;
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task rc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("register", exp, rd);
  endtask

  task pulse(input logic [10:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 11'h000;
  endtask

  task t_reset;
    rc(`ADDR_BUS_CONTROL, 32'h0);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h0);
    rc(`ADDR_BUS_STATUS_SECONDARY, 32'h0);
    rc(8'h10, 32'h0);
    chk("pslverr", 1, err);
    chk("release", 1, rel);
    chk("pin_alt", 0, alt);
  endtask

  task t_enable;
    apb(1'b1, `ADDR_BUS_CONTROL, 32'h3f);
    rc(`ADDR_BUS_CONTROL, 32'h20);
    chk("pin_alt", 1, alt);
    chk("release", 0, rel);
    apb(1'b1, `ADDR_BUS_CONTROL, 32'h35);
    rc(`ADDR_BUS_CONTROL, 32'h35);
    chk("gc_en", 1, gcen);
    chk("ack_en", 1, acken);
  endtask

  task t_busy;
    frame <= 1'b1;
    repeat (20) @(posedge clk);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h10);
    frame <= 1'b0;
    repeat (20) @(posedge clk);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h0);
  endtask

  task t_start;
    apb(1'b1, `ADDR_BUS_CONTROL, 32'h3d);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h02);
    chk("start_req", 1, sreq);
    pulse(11'h001);
    repeat (2) @(posedge clk);
    chk("hold", 1, hold);
    chk("irq", 1, irq);
    chk("wake", 1, wake);
    imask <= 1'b1;
    halt <= 1'b1;
    repeat (3) @(posedge clk);
    chk("irq", 0, irq);
    chk("wake", 0, wake);
    imask <= 1'b0;
    halt <= 1'b0;
    rc(`ADDR_BUS_CONTROL, 32'h35);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h83);
    apb(1'b1, `ADDR_DATA_REGISTER, 32'ha0);
    repeat (3) @(posedge clk);
    chk("dr_wdata", 32'ha0, drw);
    chk("hold", 0, hold);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h02);
  endtask

  task t_bytes;
    pulse(11'h020);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h8a);
    rc(`ADDR_DATA_REGISTER, 32'h5a);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h02);
    pulse(11'h010);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'haa);
    apb(1'b1, `ADDR_DATA_REGISTER, 32'h33);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h02);
    pulse(11'h004);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'hc2);
    rc(`ADDR_BUS_STATUS_SECONDARY, 32'h0);
    apb(1'b1, `ADDR_DATA_REGISTER, 32'hf0);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h02);
  endtask

  task t_master;
    pulse(11'h008);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h82);
    chk("hold", 1, hold);
    apb(1'b1, `ADDR_BUS_CONTROL, 32'h37);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h02);
    chk("hold", 0, hold);
    chk("stop_req", 1, preq);
    pulse(11'h002);
    rc(`ADDR_BUS_CONTROL, 32'h35);
    chk("stop_req", 0, preq);
    pulse(11'h0c0);
    rc(`ADDR_BUS_STATUS_SECONDARY, 32'h01);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h86);
    frame <= 1'b1;
    repeat (20) @(posedge clk);
    frame <= 1'b0;
    repeat (20) @(posedge clk);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h0);
    rc(`ADDR_BUS_STATUS_SECONDARY, 32'h0);
    apb(1'b1, `ADDR_BUS_CONTROL, 32'h37);
    pulse(11'h022);
    repeat (2) @(posedge clk);
    chk("release", 1, rel);
    chk("stop_req", 0, preq);
    rc(`ADDR_BUS_CONTROL, 32'h37);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h88);
    rc(`ADDR_DATA_REGISTER, 32'h5a);
    apb(1'b1, `ADDR_BUS_CONTROL, 32'h35);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h0);
    chk("release", 0, rel);
    ck <= 1'b0;
    pulse(11'h001);
    ck <= 1'b1;
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h0);
  endtask

  task t_errors;
    pulse(11'h700);
    repeat (2) @(posedge clk);
    chk("hold", 0, hold);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h80);
    rc(`ADDR_BUS_STATUS_SECONDARY, 32'h16);
    rc(`ADDR_BUS_STATUS_SECONDARY, 32'h0);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h0);
    pulse(11'h040);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h84);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h0);
  endtask

  task t_off;
    apb(1'b1, `ADDR_BUS_CONTROL, 32'h37);
    apb(1'b1, `ADDR_BUS_CONTROL, 32'h02);
    rc(`ADDR_BUS_CONTROL, 32'h02);
    chk("release", 1, rel);
    chk("pin_alt", 0, alt);
    chk("ack_en", 0, acken);
    chk("gc_en", 0, gcen);
    pulse(11'h020);
    rc(`ADDR_BUS_STATUS_PRIMARY, 32'h0);
    apb(1'b1, `ADDR_BUS_CONTROL, 32'h21);
    rc(`ADDR_BUS_CONTROL, 32'h22);
  endtask

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    imask = 1'b0;
    halt = 1'b0;
    frame = 1'b0;
    ck = 1'b1;
    ev = 11'h000;
    rdata8 = 8'h5a;
    n_errors = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_enable;
    t_busy;
    t_start;
    t_bytes;
    t_master;
    t_errors;
    t_off;
    complete_run;
  end
endmodule
